// File: pkg/fcs_consts.svh
// Constants for the flash setup and security register block.
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// Command codes; the values are arbitrary and set per product.
`define FCS_OP_ENTER_WIDE     8'hA1
`define FCS_OP_EXIT_WIDE      8'hA2
`define FCS_OP_READ_SETUP     8'hA3
`define FCS_OP_WRITE_STATUS   8'hA4
`define FCS_OP_READ_SECURITY  8'hA5
`define FCS_OP_WRITE_SECURITY 8'hA6

// Setup register field positions.
`define FCS_SETUP_DUMMY_HI    7
`define FCS_SETUP_DUMMY_LO    6
`define FCS_SETUP_WIDE_BIT    5
`define FCS_SETUP_PREAMBLE    4
`define FCS_SETUP_ORIGIN      3
`define FCS_SETUP_DRIVE_HI    2
`define FCS_SETUP_DRIVE_LO    0

// Security register field positions.
`define FCS_SEC_SCHEME        7
`define FCS_SEC_ERASE_FAIL    6
`define FCS_SEC_PROG_FAIL     5
`define FCS_SEC_RESERVED      4
`define FCS_SEC_ERASE_PAUSED  3
`define FCS_SEC_PROG_PAUSED   2
`define FCS_SEC_USER_LOCK     1
`define FCS_SEC_FACTORY_LOCK  0

// Reset values.
`define FCS_DUMMY_RESET       2'h0
`define FCS_DRIVE_RESET       3'h7
`define FCS_SETUP_RESET       8'h07

// Dummy clocks per code 00/01/10/11 for each read family.
`define FCS_DC_FAST_0         4'h8
`define FCS_DC_FAST_1         4'h6
`define FCS_DC_FAST_2         4'h8
`define FCS_DC_FAST_3         4'hA
`define FCS_DC_DUALIO_0       4'h4
`define FCS_DC_DUALIO_1       4'h6
`define FCS_DC_DUALIO_2       4'h8
`define FCS_DC_DUALIO_3       4'hA
`define FCS_DC_QUADIO_0       4'h6
`define FCS_DC_QUADIO_1       4'h4
`define FCS_DC_QUADIO_2       4'h8
`define FCS_DC_QUADIO_3       4'hA

`endif

// File: pkg/fcs_pkg.sv
// Types shared by the flash setup and security register block.
package fcs_pkg;

    // Setup register layout, most significant field first.
    typedef struct packed {
        logic [1:0] dummy_select;
        logic       wide_address_flag;
        logic       preamble_enable;
        logic       protection_origin;
        logic [2:0] drive_strength_select;
    } fcs_setup_t;

    // Completion and suspend events from the program and erase engines.
    typedef struct packed {
        logic erase_end;
        logic erase_failed;
        logic program_end;
        logic program_failed;
        logic erase_suspend;
        logic erase_resume;
        logic program_suspend;
        logic program_resume;
    } fcs_event_t;

    // Non-volatile bits as held by the storage outside this block.
    typedef struct packed {
        logic protect_scheme_select;
        logic protection_origin;
        logic user_otp_lock;
        logic factory_lock;
    } fcs_nv_t;

    // Dummy clock counts per read family.
    typedef struct packed {
        logic [3:0] fast_read;
        logic [3:0] dual_io_read;
        logic [3:0] quad_io_read;
    } fcs_dummy_t;

    // Serial command decoder states.
    typedef enum logic [2:0] {
        FCS_ST_COMMAND   = 3'b000,
        FCS_ST_STATUS    = 3'b001,
        FCS_ST_SETUP     = 3'b010,
        FCS_ST_READ      = 3'b011,
        FCS_ST_IGNORE    = 3'b100
    } fcs_state_t;

endpackage

// File: verilog/fcs_sync.sv
// Two-flop synchroniser for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module fcs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset.
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    // Asynchronous level in, synchronised level out.
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;

    // The first stage feeds only the second stage.
    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            meta_reg <= INIT;
            o_sync   <= INIT;
        end else begin
            meta_reg <= meta_next;
            o_sync   <= sync_next;
        end
    end
endmodule
`default_nettype wire

// File: verilog/fcs_dummy_lut.sv
// Dummy clock count lookup for the three read families.
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.svh"
module fcs_dummy_lut (
    // Dummy select code from the setup register.
    input  wire logic [1:0]         i_dummy_select,
    // Counts for each read family.
    output fcs_pkg::fcs_dummy_t     o_dummy
);
    import fcs_pkg::*;

    // Family 0 is fast read, 1 dual I/O and 2 quad I/O.
    function automatic logic [3:0] dummy_count(input logic [1:0] family, input logic [1:0] code);
        logic [3:0] count;
        count = `FCS_DC_FAST_0;
        case ({family, code})
            4'h0:    count = `FCS_DC_FAST_0;
            4'h1:    count = `FCS_DC_FAST_1;
            4'h2:    count = `FCS_DC_FAST_2;
            4'h3:    count = `FCS_DC_FAST_3;
            4'h4:    count = `FCS_DC_DUALIO_0;
            4'h5:    count = `FCS_DC_DUALIO_1;
            4'h6:    count = `FCS_DC_DUALIO_2;
            4'h7:    count = `FCS_DC_DUALIO_3;
            4'h8:    count = `FCS_DC_QUADIO_0;
            4'h9:    count = `FCS_DC_QUADIO_1;
            4'hA:    count = `FCS_DC_QUADIO_2;
            4'hB:    count = `FCS_DC_QUADIO_3;
            default: count = `FCS_DC_FAST_0;
        endcase
        return count;
    endfunction

    // Each family looks up the same code in its own column.
    always_comb begin
        o_dummy.fast_read    = dummy_count(2'h0, i_dummy_select);
        o_dummy.dual_io_read = dummy_count(2'h1, i_dummy_select);
        o_dummy.quad_io_read = dummy_count(2'h2, i_dummy_select);
    end
endmodule
`default_nettype wire

// File: verilog/fcs_config_security.sv
// Setup and security registers of a serial flash, reached over the serial pins.
//
// What this block does
// (R1) Enter-wide command sets wide address flag.
// (R2) Wide address flag is zero after reset.
// (R3) Exit-wide command or power loss clears flag.
// (R4) Setup register layout; protection origin is OTP.
// (R5) Dummy clocks follow select code and read family.
// (R6) Erase failure or protected erase sets erase fail.
// (R7) Next successful erase clears erase fail.
// (R8) Fail flags never stop running operations.
// (R9) Program failure or protected program sets fail.
// (R10) Next successful program clears program fail.
// (R11) Program fail reads zero after reset.
// (R12) Erase suspend sets, resume clears erase paused.
// (R13) Erase paused reads zero after reset.
// (R14) Program suspend sets, resume clears program paused.
// (R15) Program paused reads zero after reset.
// (R16) Bit zero reports factory lock of OTP.
// (R17) Write-security command sets the OTP user lock.
// (R18) User lock freezes itself and OTP area.
// (R19) Secured OTP mode blocks main array access.
// (R20) Only write-status changes drive, preamble, origin.
// (R21) Preamble enable is zero after reset.
// (R22) Drive strength resets to strongest, passed through.
// (R23) Security bit four reads zero, ignores writes.
`timescale 1ns/10ps
`default_nettype none
`include "fcs_consts.svh"
module fcs_config_security (
    // Clock and reset.
    input  wire logic                i_clock,
    input  wire logic                i_reset,
    // Serial pins from the host, mode 0, single line.
    input  wire logic                i_sclk,
    input  wire logic                i_cs_n,
    input  wire logic                i_si,
    output logic                     o_so,
    output logic                     o_so_oe,
    // Device state from the rest of the flash, same clock.
    input  wire logic                i_write_enable_latch,
    input  wire logic                i_secured_otp_mode,
    input  wire fcs_pkg::fcs_event_t i_events,
    input  wire fcs_pkg::fcs_nv_t    i_nv,
    // Settings and state towards the rest of the flash.
    output fcs_pkg::fcs_setup_t      o_setup,
    output fcs_pkg::fcs_dummy_t      o_dummy,
    output logic                     o_array_access_block,
    output logic                     o_otp_area_writable,
    output logic [7:0]               o_security
);
    import fcs_pkg::*;

    // Synchronised pins and the previous serial clock value.
    logic [2:0]   pins_sync;
    logic         sclk_s;
    logic         cs_n_s;
    logic         si_s;
    logic         sclk_prev_reg;
    logic         sclk_rise;
    logic         sclk_fall;

    // Serial decoder state.
    fcs_state_t   state_reg;
    fcs_state_t   state_next;
    logic [2:0]   bit_count_reg;
    logic [2:0]   bit_count_next;
    logic [7:0]   rx_reg;
    logic [7:0]   rx_next;
    logic [7:0]   tx_reg;
    logic [7:0]   tx_next;
    logic         so_next;
    logic         so_oe_next;
    logic         byte_done;
    logic [7:0]   rx_byte;

    // Register contents.
    fcs_setup_t   setup_next;
    logic         nv_loaded_reg;
    logic         nv_loaded_next;
    logic         scheme_reg;
    logic         scheme_next;
    logic         factory_lock_reg;
    logic         factory_lock_next;
    logic         user_lock_reg;
    logic         user_lock_next;
    logic         erase_fail_reg;
    logic         erase_fail_next;
    logic         prog_fail_reg;
    logic         prog_fail_next;
    logic         erase_paused_reg;
    logic         erase_paused_next;
    logic         prog_paused_reg;
    logic         prog_paused_next;
    logic [7:0]   security_byte;
    fcs_dummy_t   dummy_lookup;
    logic         block_next;
    logic         otp_writable_next;

    // Every pin crosses two flops before any logic reads it.
    fcs_sync #(
        .WIDTH (3),
        .INIT  (3'h2)
    ) u_pin_sync (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_async ({i_sclk, i_cs_n, i_si}),
        .o_sync  (pins_sync)
    );

    assign sclk_s    = pins_sync[2];
    assign cs_n_s    = pins_sync[1];
    assign si_s      = pins_sync[0];
    assign sclk_rise = sclk_s & ~sclk_prev_reg & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_prev_reg & ~cs_n_s;
    assign rx_byte   = {rx_reg[6:0], si_s};
    assign byte_done = sclk_rise & (bit_count_reg == 3'h7);

    // Security register image; the reserved bit is tied low.
    always_comb begin
        security_byte                         = 8'h00;
        security_byte[`FCS_SEC_SCHEME]        = scheme_reg;
        security_byte[`FCS_SEC_ERASE_FAIL]    = erase_fail_reg;
        security_byte[`FCS_SEC_PROG_FAIL]     = prog_fail_reg;
        security_byte[`FCS_SEC_RESERVED]      = 1'b0; // R23
        security_byte[`FCS_SEC_ERASE_PAUSED]  = erase_paused_reg;
        security_byte[`FCS_SEC_PROG_PAUSED]   = prog_paused_reg;
        security_byte[`FCS_SEC_USER_LOCK]     = user_lock_reg;
        security_byte[`FCS_SEC_FACTORY_LOCK]  = factory_lock_reg; // R16
    end

    // Serial decoder and setup register. Bytes are taken on the rising
    // edge of the serial clock and answers shifted on the falling edge.
    // Raising chip select abandons any command part way through.
    always_comb begin
        state_next     = state_reg;
        bit_count_next = bit_count_reg;
        rx_next        = rx_reg;
        tx_next        = tx_reg;
        so_next        = o_so;
        so_oe_next     = o_so_oe;
        setup_next     = o_setup;
        user_lock_next = user_lock_reg;
        if (cs_n_s) begin
            state_next     = FCS_ST_COMMAND;
            bit_count_next = 3'h0;
            so_oe_next     = 1'b0;
        end else begin
            if (sclk_rise) begin
                rx_next        = rx_byte;
                bit_count_next = bit_count_reg + 3'h1;
            end
            if (sclk_fall && state_reg == FCS_ST_READ) begin
                // The byte repeats for as long as the host keeps clocking.
                so_next    = tx_reg[7];
                so_oe_next = 1'b1;
                tx_next    = {tx_reg[6:0], tx_reg[7]};
            end
            if (byte_done) begin
                case (state_reg)
                    FCS_ST_COMMAND: begin
                        state_next = FCS_ST_IGNORE;
                        case (rx_byte)
                            `FCS_OP_ENTER_WIDE: begin
                                setup_next.wide_address_flag = 1'b1; // R1
                            end
                            `FCS_OP_EXIT_WIDE: begin
                                setup_next.wide_address_flag = 1'b0; // R3
                            end
                            `FCS_OP_READ_SETUP: begin
                                state_next = FCS_ST_READ;
                                tx_next    = o_setup; // R4
                            end
                            `FCS_OP_READ_SECURITY: begin
                                state_next = FCS_ST_READ;
                                tx_next    = security_byte;
                            end
                            `FCS_OP_WRITE_STATUS: begin
                                if (i_write_enable_latch) begin
                                    state_next = FCS_ST_STATUS;
                                end
                            end
                            `FCS_OP_WRITE_SECURITY: begin
                                // A locked bit stays locked; writing it again changes nothing.
                                if (i_write_enable_latch) begin
                                    user_lock_next = 1'b1; // R17
                                end
                            end
                            default: begin
                                state_next = FCS_ST_IGNORE;
                            end
                        endcase
                    end
                    FCS_ST_STATUS: begin
                        // The first data byte belongs to the status register outside.
                        state_next = FCS_ST_SETUP;
                    end
                    FCS_ST_SETUP: begin
                        state_next = FCS_ST_IGNORE;
                        setup_next.dummy_select = rx_byte[`FCS_SETUP_DUMMY_HI:`FCS_SETUP_DUMMY_LO];
                        setup_next.preamble_enable = rx_byte[`FCS_SETUP_PREAMBLE]; // R20
                        setup_next.drive_strength_select =
                            rx_byte[`FCS_SETUP_DRIVE_HI:`FCS_SETUP_DRIVE_LO]; // R20 R22
                        // The origin bit is one-time programmable: it can only be set.
                        setup_next.protection_origin =
                            o_setup.protection_origin | rx_byte[`FCS_SETUP_ORIGIN]; // R4 R20
                    end
                    FCS_ST_READ: begin
                        state_next = FCS_ST_READ;
                    end
                    FCS_ST_IGNORE: begin
                        state_next = FCS_ST_IGNORE;
                    end
                    default: begin
                        state_next = FCS_ST_IGNORE;
                    end
                endcase
            end
        end
        // The origin bit and the user lock come from storage on the first cycle after reset.
        if (!nv_loaded_reg) begin
            setup_next.protection_origin = i_nv.protection_origin;
            user_lock_next               = i_nv.user_otp_lock;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sclk_prev_reg  <= 1'b0;
            state_reg      <= FCS_ST_COMMAND;
            bit_count_reg  <= 3'h0;
            rx_reg         <= 8'h00;
            tx_reg         <= 8'h00;
            o_so           <= 1'b0;
            o_so_oe        <= 1'b0;
            o_setup        <= `FCS_SETUP_RESET; // R2 R3 R21 R22
            user_lock_reg  <= 1'b0;
        end else begin
            sclk_prev_reg  <= sclk_s;
            state_reg      <= state_next;
            bit_count_reg  <= bit_count_next;
            rx_reg         <= rx_next;
            tx_reg         <= tx_next;
            o_so           <= so_next;
            o_so_oe        <= so_oe_next;
            o_setup        <= setup_next;
            user_lock_reg  <= user_lock_next;
        end
    end

    // Security flags driven by the engines. A set in the same cycle as a
    // clear wins. The flags are reports only: nothing here feeds back to
    // the engines, so a failure never stops a running operation.
    always_comb begin
        nv_loaded_next    = 1'b1;
        scheme_next       = i_nv.protect_scheme_select;
        factory_lock_next = i_nv.factory_lock; // R16
        erase_fail_next   = erase_fail_reg;
        prog_fail_next    = prog_fail_reg;
        erase_paused_next = erase_paused_reg;
        prog_paused_next  = prog_paused_reg;
        if (i_events.erase_end) begin
            erase_fail_next = i_events.erase_failed; // R6 R7 R8
        end
        if (i_events.program_end) begin
            prog_fail_next = i_events.program_failed; // R9 R10 R8
        end
        if (i_events.erase_suspend) begin
            erase_paused_next = 1'b1; // R12
        end else if (i_events.erase_resume) begin
            erase_paused_next = 1'b0; // R12
        end
        if (i_events.program_suspend) begin
            prog_paused_next = 1'b1; // R14
        end else if (i_events.program_resume) begin
            prog_paused_next = 1'b0; // R14
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            nv_loaded_reg    <= 1'b0;
            scheme_reg       <= 1'b0;
            factory_lock_reg <= 1'b0;
            erase_fail_reg   <= 1'b0;
            prog_fail_reg    <= 1'b0; // R11
            erase_paused_reg <= 1'b0; // R13
            prog_paused_reg  <= 1'b0; // R15
        end else begin
            nv_loaded_reg    <= nv_loaded_next;
            scheme_reg       <= scheme_next;
            factory_lock_reg <= factory_lock_next;
            erase_fail_reg   <= erase_fail_next;
            prog_fail_reg    <= prog_fail_next;
            erase_paused_reg <= erase_paused_next;
            prog_paused_reg  <= prog_paused_next;
        end
    end

    // Dummy counts follow the setup register one cycle later.
    fcs_dummy_lut u_dummy_lut (
        .i_dummy_select (o_setup.dummy_select),
        .o_dummy        (dummy_lookup)
    );

    // Registered outputs towards the array and read paths.
    always_comb begin
        block_next        = i_secured_otp_mode; // R19
        otp_writable_next = ~user_lock_reg; // R18
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_dummy              <= {`FCS_DC_FAST_0, `FCS_DC_DUALIO_0, `FCS_DC_QUADIO_0};
            o_array_access_block <= 1'b0;
            o_otp_area_writable  <= 1'b0;
            o_security           <= 8'h00;
        end else begin
            o_dummy              <= dummy_lookup; // R5
            o_array_access_block <= block_next;
            o_otp_area_writable  <= otp_writable_next;
            o_security           <= security_byte;
        end
    end
endmodule
`default_nettype wire

// File: sim/fcs_config_security_properties.sv
// Checker of the setup and security register outputs against their causes.
`timescale 1ns/10ps
`default_nettype none
module fcs_config_security_properties (
    // Clock and reset.
    input wire logic                i_clock,
    input wire logic                i_reset,
    // Inputs that cause output changes.
    input wire logic                i_secured_otp_mode,
    input wire fcs_pkg::fcs_event_t i_events,
    input wire fcs_pkg::fcs_nv_t    i_nv,
    // Registered outputs under watch.
    input wire fcs_pkg::fcs_setup_t o_setup,
    input wire fcs_pkg::fcs_dummy_t o_dummy,
    input wire logic                o_array_access_block,
    input wire logic [7:0]          o_security
);
    import fcs_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    // Counts per code for fast, dual I/O and quad I/O reads.
    function automatic fcs_dummy_t dlut(input logic [1:0] c);
        case (c)
            2'h0: return {4'h8, 4'h4, 4'h6};
            2'h1: return {4'h6, 4'h6, 4'h4};
            2'h2: return {4'h8, 4'h8, 4'h8};
            default: return {4'hA, 4'hA, 4'hA};
        endcase
    endfunction

    // Reset is checked with its own disable, since it is the cause here.
    reset_values_a: assert property (disable iff (1'b0) i_reset |=>
        o_setup == 8'h07 && o_security == 8'h00) else $error("reset values wrong");
    block_follow_a: assert property (!$past(i_reset) |->
        o_array_access_block == $past(i_secured_otp_mode)) else $error("array block wrong");
    dummy_lookup_a: assert property (!$past(i_reset) |->
        o_dummy == dlut($past(o_setup.dummy_select))) else $error("dummy count wrong");
    factory_bit_a: assert property (!$past(i_reset) && !$past(i_reset, 2) |->
        o_security[0] == $past(i_nv.factory_lock, 2)) else $error("factory bit wrong");
    reserved_zero_a: assert property (o_security[4] == 1'b0) else $error("reserved bit set");
    erase_fail_set_a: assert property (i_events.erase_end && i_events.erase_failed |-> ##2
        o_security[6]) else $error("erase fail not set");
    erase_fail_clr_a: assert property (i_events.erase_end && !i_events.erase_failed |-> ##2
        !o_security[6]) else $error("erase fail not cleared");
    prog_fail_set_a: assert property (i_events.program_end && i_events.program_failed |-> ##2
        o_security[5]) else $error("program fail not set");
    prog_fail_clr_a: assert property (i_events.program_end && !i_events.program_failed |-> ##2
        !o_security[5]) else $error("program fail not cleared");
    erase_pause_a: assert property (i_events.erase_suspend |-> ##2 o_security[3]
        ) else $error("erase pause not set");
    prog_pause_a: assert property ($rose(o_security[2]) |->
        $past(i_events.program_suspend, 2)) else $error("program pause without suspend");

    // Main scenarios.
    wide_seen_c: cover property ($rose(o_setup.wide_address_flag));
    lock_seen_c: cover property ($rose(o_security[1]));
    fail_seen_c: cover property ($rose(o_security[6]));
endmodule
bind fcs_config_security fcs_config_security_properties u_fcs_props (
    .i_clock(i_clock), .i_reset(i_reset), .i_secured_otp_mode(i_secured_otp_mode),
    .i_events(i_events), .i_nv(i_nv), .o_setup(o_setup), .o_dummy(o_dummy),
    .o_array_access_block(o_array_access_block), .o_security(o_security));
`default_nettype wire

// File: sim/fcs_host.sv
// Host serial controller model sending mode 0 frames.
`timescale 1ns/10ps
`default_nettype none
module fcs_host (
    // Sampling clock.
    input  wire logic i_clock,
    // Serial pins.
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_si,
    input  wire logic i_so
);
    // The link clock stands low between frames.
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_si   = 1'b1;
    end

    // Shifts n bits MSB first at 80 ns a bit; returned data is taken at each rise.
    task automatic frame(input logic [23:0] tx, input int n, output logic [7:0] rx);
        @(negedge i_clock);
        o_cs_n = 1'b0;
        rx = 8'h00;
        repeat (5) @(negedge i_clock);
        for (int i = 0; i < n; i++) begin
            o_si = tx[23 - i];
            repeat (5) @(negedge i_clock);
            o_sclk = 1'b1;
            rx = {rx[6:0], i_so};
            repeat (5) @(negedge i_clock);
            o_sclk = 1'b0;
        end
        repeat (5) @(negedge i_clock);
        o_cs_n = 1'b1;
        o_si = ~o_si; // A released line must not keep its last level.
        repeat (10) @(negedge i_clock);
    endtask
endmodule
`default_nettype wire

// File: sim/fcs_config_security_bench.sv
// Self-checking bench for the flash setup and security registers.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module fcs_config_security_bench;
    import fcs_pkg::*;
    logic       i_clock = 1'b0;
    logic       i_reset = 1'b1;
    logic       sclk, cs_n, si, so, so_oe, blk, otp_wr;
    logic       wel = 1'b0;
    logic       otp_mode = 1'b0;
    fcs_event_t ev = '0;
    fcs_event_t e;
    fcs_nv_t    nv = '0;
    fcs_setup_t setup;
    fcs_dummy_t dummy;
    logic [7:0] sec, rx, es, ss, d;
    int         fails = 0;
    int         checks = 0;
    int         cyc = 0;
    int         fr[4] = '{8, 6, 8, 10};
    int         du[4] = '{4, 6, 8, 10};
    int         qu[4] = '{6, 4, 8, 10};
    logic [7:0] evs[8] = '{8'hC0, 8'h08, 8'h30, 8'h02, 8'h80, 8'h04, 8'h20, 8'h01};

    fcs_config_security u_fcs_config_security (
        .i_clock(i_clock), .i_reset(i_reset), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
        .o_so(so), .o_so_oe(so_oe), .i_write_enable_latch(wel), .i_secured_otp_mode(otp_mode),
        .i_events(ev), .i_nv(nv), .o_setup(setup), .o_dummy(dummy),
        .o_array_access_block(blk), .o_otp_area_writable(otp_wr), .o_security(sec));
    fcs_host u_fcs_host (.i_clock(i_clock), .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so));

    always #4 i_clock = ~i_clock;

    // A hang is cut short well beyond the few thousand cycles the run needs.
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Reads both registers over the link and compares them and the output images.
    task automatic check_regs();
        u_fcs_host.frame({8'hA3, 16'h0000}, 16, rx);
        `CHK(rx, es)
        `CHK(setup, es)
        u_fcs_host.frame({8'hA5, 16'h0000}, 16, rx);
        `CHK(rx, ss)
        `CHK(sec, ss)
        `CHK(so_oe, 1'b0)
    endtask

    // One engine event pulse, then time for the image to follow.
    task automatic pulse(input fcs_event_t p);
        ev = p;
        @(negedge i_clock);
        ev = '0;
        repeat (3) @(negedge i_clock);
    endtask

    initial begin
        void'($urandom(32'h1800860D));
        nv = 4'($urandom) & 4'hD;
        repeat (4) @(negedge i_clock);
        i_reset = 1'b0;
        repeat (6) @(negedge i_clock);
        es = {4'h0, nv.protection_origin, 3'h7};
        ss = {nv.protect_scheme_select, 6'h00, nv.factory_lock};
        check_regs();
        u_fcs_host.frame({8'hA1, 16'h0000}, 8, rx);
        es[5] = 1'b1;
        `CHK(setup, es)
        u_fcs_host.frame({8'hA4, 16'($urandom)}, 24, rx);
        `CHK(setup, es)
        wel = 1'b1;
        // Every dummy code; wide flag must survive and the origin bit only ever sets.
        for (int k = 0; k < 4; k++) begin
            d = {2'(k), 6'($urandom)};
            u_fcs_host.frame({8'hA4, 8'($urandom), d}, 24, rx);
            es = {d[7:6], es[5], d[4], es[3] | d[3], d[2:0]};
            `CHK(setup, es)
            `CHK(dummy, {4'(fr[k]), 4'(du[k]), 4'(qu[k])})
        end
        u_fcs_host.frame({8'hA2, 16'h0000}, 8, rx);
        es[5] = 1'b0;
        check_regs();
        // Interleaved fail and suspend events, one per pulse; flags must not disturb each other.
        for (int i = 0; i < 8; i++) begin
            e = evs[i];
            if (e.erase_end) ss[6] = e.erase_failed;
            if (e.program_end) ss[5] = e.program_failed;
            if (e.erase_suspend) ss[3] = 1'b1;
            else if (e.erase_resume) ss[3] = 1'b0;
            if (e.program_suspend) ss[2] = 1'b1;
            else if (e.program_resume) ss[2] = 1'b0;
            pulse(e);
            `CHK(sec, ss)
            `CHK(setup, es)
        end
        otp_mode = 1'b1;
        repeat (3) @(negedge i_clock);
        `CHK(blk, 1'b1)
        otp_mode = 1'b0;
        repeat (3) @(negedge i_clock);
        `CHK(blk, 1'b0)
        wel = 1'b0;
        u_fcs_host.frame({8'hA6, 16'h0000}, 8, rx);
        `CHK(sec, ss)
        `CHK(otp_wr, 1'b1)
        wel = 1'b1;
        u_fcs_host.frame({8'hA6, 16'h0000}, 8, rx);
        ss[1] = 1'b1;
        `CHK(sec, ss)
        `CHK(otp_wr, 1'b0)
        u_fcs_host.frame({8'hA6, 16'h0000}, 8, rx);
        check_regs();
        tally_and_finish();
    end
endmodule
`default_nettype wire
